// >>> logic/hbdc_driver.sv
/*
  control logic of four independent half-bridges with dead time and fixed
  off-time current chopping. assumes pins and trip comparators are asynchronous
  to clk and are synchronised here; clk is the internal 10 MHz oscillator.
*/
// What this block does
// - sleep low forces all four half-bridge outputs high impedance
// - enable low makes that channel high impedance
// - enabled: level 0 low side, 1 high side
// - dead time between high and low switch on level changes and on exit from a chop off time; none on entry to a chop off time
// - slew select picks 70 or 140 ns on the large package only
// - four channels run independently and concurrently
// - fast decay off disables, slow shorts winding
// - regulate ground loads with 16 us off time
// - trip while high: low side for off time
// - still tripped at end: repeat off time
// - large package: comparator of sense against reference
// - small package: threshold from reference over constant
// - no trip allows 100 percent on duty
// - sensing only on high side switch
// - ignore trip for 1.5 us after turn-on
// - trip accepted after 0.5 us deglitch
`timescale 1ns/100ps
`include "hbdc_map.svh"

module hbdc_driver (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control pins from the external controller
  input wire logic sleep_bar_input,
  input wire logic [3:0] level_command,
  input wire logic [3:0] channel_allow,
  input wire logic slew_select,
  input wire logic large_package,
  // trip comparator outputs, one per channel
  input wire logic [3:0] chop_threshold,
  // gate drive to the power stage
  output hbdc_pkg::hbdc_gate_t [3:0] half_bridge_node,
  output logic slew_fast
);

  localparam int unsigned CW = `HBDC_CNT_W;
  // last count of an off period: counting 0 to this value is exactly the off time
  localparam logic [CW-1:0] OFF_LAST = CW'(`HBDC_OFF_CYC - 1);
  localparam logic [CW-1:0] BLANK_N = CW'(`HBDC_BLANK_CYC);
  localparam logic [CW-1:0] DEG_N = CW'(`HBDC_DEGLITCH_CYC);
  localparam logic [CW-1:0] DEAD_N = CW'(`HBDC_DEAD_CYC);

  // two-stage synchronisers for every pin
  logic [14:0] sync1_r;
  logic [14:0] sync2_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 15'h0000;
      sync2_r <= 15'h0000;
    end else begin
      sync1_r <= {large_package, slew_select, sleep_bar_input, chop_threshold,
                  channel_allow, level_command};
      sync2_r <= sync1_r;
    end
  end

  logic [3:0] lvl;
  logic [3:0] allow;
  logic [3:0] trip_raw;
  logic awake;
  logic slew_sel;
  logic pkg_large;
  assign lvl = sync2_r[3:0];
  assign allow = sync2_r[7:4];
  assign trip_raw = sync2_r[11:8];
  assign awake = sync2_r[12];
  assign slew_sel = sync2_r[13];
  assign pkg_large = sync2_r[14];

  // slew rate choice: only the large package may select the fast edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slew_fast <= 1'b0;
    end else begin
      slew_fast <= pkg_large & slew_sel;
    end
  end

  // one independent state machine per channel
  genvar ch;
  generate
    for (ch = 0; ch < `HBDC_NCH; ch++) begin : g_ch
      hbdc_pkg::hbdc_state_t st_r;
      hbdc_pkg::hbdc_state_t st_nxt;
      logic [CW-1:0] ph_cnt_r;
      logic [CW-1:0] deg_cnt_r;
      logic trip_ok;
      logic ph_done;
      logic blank_over;
      logic want_on;
      logic enter;

      // the comparator is acted on only after blanking, and a trip counts
      // once it has stayed asserted for the deglitch time, which may pass during blanking
      assign blank_over = (ph_cnt_r >= BLANK_N);
      assign trip_ok = (deg_cnt_r >= DEG_N);
      assign ph_done = (ph_cnt_r >= OFF_LAST);
      assign want_on = awake & allow[ch];

      // deglitch counter runs on the comparator level of this channel only
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          deg_cnt_r <= '0;
        end else if (!trip_raw[ch] || enter) begin
          deg_cnt_r <= '0;
        end else if (!trip_ok) begin
          deg_cnt_r <= deg_cnt_r + CW'(1);
        end
      end

      // next-state logic: truth table, dead time and chopping
      always_comb begin
        st_nxt = st_r;
        if (!want_on) begin
          st_nxt = hbdc_pkg::HBDC_ST_HIZ;
        end else begin
          case (st_r)
            hbdc_pkg::HBDC_ST_HIZ: begin
              st_nxt = lvl[ch] ? hbdc_pkg::HBDC_ST_DEAD_HI : hbdc_pkg::HBDC_ST_DEAD_LO;
            end
            hbdc_pkg::HBDC_ST_DEAD_HI: begin
              if (!lvl[ch]) begin
                st_nxt = hbdc_pkg::HBDC_ST_DEAD_LO;
              end else if (ph_cnt_r >= DEAD_N) begin
                st_nxt = hbdc_pkg::HBDC_ST_HIGH;
              end
            end
            hbdc_pkg::HBDC_ST_HIGH: begin
              if (!lvl[ch]) begin
                st_nxt = hbdc_pkg::HBDC_ST_DEAD_LO;
              end else if (blank_over && trip_ok) begin
                st_nxt = hbdc_pkg::HBDC_ST_CHOP;
              end
            end
            hbdc_pkg::HBDC_ST_DEAD_LO: begin
              if (lvl[ch] && ph_cnt_r >= DEAD_N) begin
                st_nxt = hbdc_pkg::HBDC_ST_DEAD_HI;
              end else if (!lvl[ch] && ph_cnt_r >= DEAD_N) begin
                st_nxt = hbdc_pkg::HBDC_ST_LOW;
              end
            end
            hbdc_pkg::HBDC_ST_LOW: begin
              if (lvl[ch]) begin
                st_nxt = hbdc_pkg::HBDC_ST_DEAD_HI;
              end
            end
            hbdc_pkg::HBDC_ST_CHOP: begin
              if (!lvl[ch]) begin
                st_nxt = hbdc_pkg::HBDC_ST_LOW;
              end else if (ph_done && !trip_raw[ch]) begin
                st_nxt = hbdc_pkg::HBDC_ST_DEAD_HI;
              end
            end
            default: begin
              st_nxt = hbdc_pkg::HBDC_ST_HIZ;
            end
          endcase
        end
      end

      // a new phase starts whenever the state changes, or an off time is renewed
      assign enter = (st_nxt != st_r) ||
                     (st_r == hbdc_pkg::HBDC_ST_CHOP && ph_done);

      // state register
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          st_r <= hbdc_pkg::HBDC_ST_HIZ;
        end else begin
          st_r <= st_nxt;
        end
      end

      // phase counter for dead, blanking and off intervals
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ph_cnt_r <= '0;
        end else if (enter) begin
          ph_cnt_r <= '0;
        end else if (ph_cnt_r != {CW{1'b1}}) begin
          ph_cnt_r <= ph_cnt_r + CW'(1);
        end
      end

      // gate outputs registered; never both on, dead states drive neither
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          half_bridge_node[ch] <= '0;
        end else begin
          half_bridge_node[ch].high_on <= (st_nxt == hbdc_pkg::HBDC_ST_HIGH);
          half_bridge_node[ch].low_on <= (st_nxt == hbdc_pkg::HBDC_ST_LOW) ||
                                         (st_nxt == hbdc_pkg::HBDC_ST_CHOP);
        end
      end
    end
  endgenerate

endmodule // hbdc_driver

// >>> logic/hbdc_map.svh
/*
  timing counts and sizes for the four-channel half-bridge driver logic.
  assumes a 10 MHz core clock; included by the package and the driver module.
*/
`ifndef HBDC_MAP_SVH
`define HBDC_MAP_SVH

`define HBDC_CLK_MHZ 10
`define HBDC_OFF_NS 16000
`define HBDC_BLANK_NS 1500
`define HBDC_DEGLITCH_NS 500
`define HBDC_DEAD_NS 200
`define HBDC_SLEW_FAST_NS 70
`define HBDC_SLEW_SLOW_NS 140
`define HBDC_NS_PER_CYC 100
`define HBDC_OFF_CYC ((`HBDC_OFF_NS + `HBDC_NS_PER_CYC - 1) / `HBDC_NS_PER_CYC)
`define HBDC_BLANK_CYC ((`HBDC_BLANK_NS + `HBDC_NS_PER_CYC - 1) / `HBDC_NS_PER_CYC)
`define HBDC_DEGLITCH_CYC ((`HBDC_DEGLITCH_NS + `HBDC_NS_PER_CYC - 1) / `HBDC_NS_PER_CYC)
`define HBDC_DEAD_CYC ((`HBDC_DEAD_NS + `HBDC_NS_PER_CYC - 1) / `HBDC_NS_PER_CYC)
`define HBDC_CNT_W 8
`define HBDC_NCH 4

`endif

// >>> logic/hbdc_pkg.sv
/*
  types shared by the half-bridge driver logic and its bench.
  assumes hbdc_map.svh is on the include path.
*/
`include "hbdc_map.svh"

package hbdc_pkg;

  // state of one half-bridge
  typedef enum logic [2:0] {
    HBDC_ST_HIZ = 3'b000,
    HBDC_ST_DEAD_HI = 3'b001,
    HBDC_ST_HIGH = 3'b010,
    HBDC_ST_DEAD_LO = 3'b011,
    HBDC_ST_LOW = 3'b100,
    HBDC_ST_CHOP = 3'b101
  } hbdc_state_t;

  // gate drive of one half-bridge
  typedef struct packed {
    logic high_on;
    logic low_on;
  } hbdc_gate_t;

endpackage

// >>> verif/hbdc_driver_sva.sv
/* port assertions for the half-bridge driver.
   assumes a bind from the bench top. */
`timescale 1ns/100ps
module hbdc_driver_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic sleep_bar_input,
  input wire logic [3:0] level_command,
  input wire logic [3:0] channel_allow,
  input wire logic slew_select,
  input wire logic large_package,
  input wire logic [3:0] chop_threshold,
  // outputs
  input wire hbdc_pkg::hbdc_gate_t [3:0] half_bridge_node,
  input wire logic slew_fast
);
  logic [3:0] hi_w;
  logic [3:0] lo_w;
  // split the gate pairs per side
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hi_w[i] = half_bridge_node[i].high_on;
      lo_w[i] = half_bridge_node[i].low_on;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // channel 0 steadily driving high
  sequence s_on0;
    (sleep_bar_input && channel_allow[0] && level_command[0])[*6];
  endsequence
  chk_sleep_off: assert property (!sleep_bar_input[*4] |-> half_bridge_node == 8'h00)
    else $error("gate on in sleep");
  chk_allow_off: assert property (!channel_allow[2][*4] |-> half_bridge_node[2] == 2'h0)
    else $error("gate on while disabled");
  chk_level_low: assert property ((sleep_bar_input && channel_allow[3] && !level_command[3])[*8]
    |-> lo_w[3] && !hi_w[3])
    else $error("low side not on");
  chk_never_both: assert property ((hi_w & lo_w) == 4'h0)
    else $error("both switches on");
  chk_dead_gap: assert property ($rose(hi_w[0]) |-> !$past(lo_w[0]) && !$past(lo_w[0], 2))
    else $error("no dead time");
  chk_slew_fast: assert property ((large_package && slew_select)[*4] |-> slew_fast)
    else $error("fast slew missing");
  chk_slew_slow: assert property (!large_package[*4] |-> !slew_fast)
    else $error("fast slew on small package");
  chk_trip_cause: assert property (s_on0 ##0 $fell(hi_w[0]) |-> $past(chop_threshold[0], 4))
    else $error("high side dropped without trip");
endmodule // hbdc_driver_sva

// >>> verif/hbdc_ctrl_model.sv
/* controller model: maps an h-bridge mode and a pwm bit onto the pins
   of channels 0 and 1. assumes the bench muxes them in. */
`timescale 1ns/100ps
module hbdc_ctrl_model (
  // command from the bench
  input wire logic [1:0] mode,
  input wire logic pwm,
  // pins toward the driver
  output logic [1:0] lvl,
  output logic [1:0] en
);
  // pwm on levels for slow decay, on enables for fast decay
  always_comb begin
    case (mode)
      2'h0: {lvl, en} = {pwm, 1'b1, 2'h3};
      2'h1: {lvl, en} = {1'b1, pwm, 2'h3};
      2'h2: {lvl, en} = {2'h1, pwm, pwm};
      default: {lvl, en} = {2'h2, pwm, pwm};
    endcase
  end
endmodule // hbdc_ctrl_model

// >>> verif/half_bridge_drive_chopper_tb_top.sv
/* self-checking bench for the half-bridge driver.
   assumes hbdc_map.svh on the include path. */
`timescale 1ns/100ps
`include "hbdc_map.svh"
module half_bridge_drive_chopper_tb_top;
  logic clk = 0, rst_n = 0, sleep_b = 0, slew_sel = 0, pkg = 0, pwm = 0, use_m = 0;
  logic [3:0] lvl = 4'h0, en = 4'h0, chop = 4'h0;
  logic [1:0] mode = 2'h0;
  logic [1:0] m_lvl, m_en;
  hbdc_pkg::hbdc_gate_t [3:0] node;
  logic sfast;
  int err_count = 0, tests_run = 0, cyc = 0, n;
  wire [3:0] lvl_w = use_m ? {lvl[3:2], m_lvl} : lvl;
  wire [3:0] en_w = use_m ? {en[3:2], m_en} : en;
  hbdc_driver dut (.clk(clk), .rst_n(rst_n), .sleep_bar_input(sleep_b), .level_command(lvl_w),
    .channel_allow(en_w), .slew_select(slew_sel), .large_package(pkg),
    .chop_threshold(chop), .half_bridge_node(node), .slew_fast(sfast));
  hbdc_ctrl_model u_model (.mode(mode), .pwm(pwm), .lvl(m_lvl), .en(m_en));
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_nodes(logic s, logic [3:0] e, logic [3:0] l);
    exp_nodes = 8'h00;
    for (int i = 0; i < 4; i++) if (s && e[i]) exp_nodes[2*i +: 2] = l[i] ? 2'h2 : 2'h1;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // clock and hang guard
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  // main sequence; chop low stands for a grounded sense pin
  initial begin
    n = $urandom(14091);
    repeat (16) @(negedge clk);
    rst_n = 1;
    repeat (20) begin
      {sleep_b, en, lvl, pkg, slew_sel} = 11'($urandom);
      repeat (12) @(negedge clk);
      check("nodes", 16'(node), 16'(exp_nodes(sleep_b, en, lvl)));
      check("slew", 16'(sfast), 16'(pkg & slew_sel));
    end
    sleep_b = 1;
    use_m = 1;
    for (int m = 0; m < 8; m++) begin
      {mode, pwm} = 3'(m);
      repeat (12) @(negedge clk);
      check("hbridge", 16'(node), 16'(exp_nodes(1'b1, en_w, lvl_w)));
    end
    use_m = 0;
    {en, lvl, chop} = 12'h321;
    repeat (12) @(negedge clk);
    lvl = 4'h3; // level high builds current
    for (n = 0; node[0].high_on !== 1'b1 && n < 50; n++) @(negedge clk);
    for (n = 0; node[0].low_on !== 1'b1 && n < 100; n++) @(negedge clk);
    check("blank", 16'(n >= `HBDC_BLANK_CYC), 16'h0001);
    for (n = 0; node[0].low_on === 1'b1 && n < 600; n++) begin
      @(negedge clk);
      if (n == 200) chop = 4'h0;
    end
    check("off_time", 16'(n), 16'(2 * `HBDC_OFF_CYC));
    check("other", 16'(node[1]), 16'h0002);
    repeat (4) @(negedge clk);
    n = 0;
    repeat (300) begin
      @(negedge clk);
      n += int'(node[0].high_on === 1'b1);
    end
    check("full_on", 16'(n), 16'h012c);
    print_verdict();
  end
endmodule // half_bridge_drive_chopper_tb_top
bind hbdc_driver hbdc_driver_sva u_sva (.clk(clk), .rst_n(rst_n),
  .sleep_bar_input(sleep_bar_input), .level_command(level_command),
  .channel_allow(channel_allow), .slew_select(slew_select), .large_package(large_package),
  .chop_threshold(chop_threshold), .half_bridge_node(half_bridge_node), .slew_fast(slew_fast));
